// ==== design/mode_based_access_checker.v ====
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "access_checker_consts.vh"

// What this block does
// - User ROM: none, read, or read-execute
// - User NVM: none, read-write, or full
// - User RAM and exchange RAM: segment permission
// - Firmware RAM access only inside exchange window
// - Boot and firmware may read security rows
// - Firmware called from system: NVM read-write
// - Crypto coprocessor always reads/writes exchange RAM
// - Optionally deny ROM reads from NVM code
// - Options block copy engine ROM, NVM reads
// - Boot: all groups but test, segcfg, banked
// - Test: all groups but segcfg, banked
// - Firmware: fwcfg read, fwos rw, hw firewalled
// - System: segcfg, sysmgmt, fwcfg, hw allowed
// - User hw registers follow fetch segment rights
// - Copy engine keeps mode from its start
// - Shared CPU registers allowed in every mode
// - Banked CPU registers only system and user
// - Control/status register readable in firmware, user
// - Clock select readable in firmware always
// - Segment config registers only in system mode
// - Table pointer shadow never readable
// - Random result read-only; cipher keys unreadable
// - Denied register access raises CPU exception
// - Table of 64 segments with bounds, relocation
// - Segment without permission matches nothing
// - Table pointer resets to zero, all disabled
module mode_based_access_checker #(
  parameter SEGS = 64,
  parameter AW = 16,
  parameter HW_IDS = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_r,
  // Memory access request
  input wire mreq_valid,
  input wire [1:0] mreq_src,
  input wire [2:0] mreq_mode,
  input wire [1:0] mreq_op,
  input wire [AW-1:0] mreq_addr,
  input wire mreq_code_in_nvm,
  input wire mreq_fw_from_sys,
  // Memory access answer
  output reg mem_grant_r,
  output reg mem_deny_r,
  output reg [AW-1:0] mem_phys_addr_r,
  // Copy engine start, done and latched mode
  input wire copy_start,
  input wire copy_done,
  output reg [2:0] copy_mode_r,
  // Register access request
  input wire sreq_valid,
  input wire sreq_wr,
  input wire [2:0] sreq_mode,
  input wire [2:0] sreq_group,
  input wire [2:0] sreq_sel,
  input wire [2:0] sreq_hw_id,
  input wire [AW-1:0] fetch_addr,
  // Register access answer
  output reg sfr_grant_r,
  output reg sfr_deny_r,
  output reg exc_r
);

  reg [HW_IDS-1:0] fw_ctrl_low_r;
  reg [HW_IDS-1:0] fw_ctrl_high_r;
  reg [7:0] xbase_low_r;
  reg [7:0] xbase_high_r;
  reg [7:0] xsize_low_r;
  reg [7:0] xsize_high_r;
  reg [2:0] cfg_r;
  reg [7:0] seg_ptr_r;
  reg [5:0] seg_index_r;
  reg [SEGS-1:0] seg_en_r;
  reg copy_busy_r;
  reg [4:0] seg_attr_m [0:SEGS-1];
  reg [AW-1:0] seg_first_m [0:SEGS-1];
  reg [AW-1:0] seg_last_m [0:SEGS-1];
  reg [AW-1:0] seg_reloc_m [0:SEGS-1];

  wire [SEGS-1:0] mem_hit;
  wire [SEGS-1:0] fetch_hit;
  wire table_on = (seg_ptr_r != 8'h00);

  // Per-entry window compare, both for data address and fetch address
  genvar g;
  generate
    for (g = 0; g < SEGS; g = g + 1) begin : seg_cmp
      assign mem_hit[g] = seg_en_r[g] && table_on &&
        (mreq_addr >= seg_first_m[g]) && (mreq_addr <= seg_last_m[g]);
      assign fetch_hit[g] = seg_en_r[g] && table_on &&
        (fetch_addr >= seg_first_m[g]) && (fetch_addr <= seg_last_m[g]);
    end
  endgenerate

  // Lowest matching entry wins when windows overlap
  reg mseg_found;
  reg [4:0] mseg_attr;
  reg [AW-1:0] mseg_reloc;
  reg fseg_found;
  reg [4:0] fseg_attr;
  integer i;
  always @* begin
    mseg_found = 1'b0;
    mseg_attr = 5'h00;
    mseg_reloc = {AW{1'b0}};
    fseg_found = 1'b0;
    fseg_attr = 5'h00;
    for (i = SEGS - 1; i >= 0; i = i - 1) begin
      if (mem_hit[i]) begin
        mseg_found = 1'b1;
        mseg_attr = seg_attr_m[i];
        mseg_reloc = seg_reloc_m[i];
      end
      if (fetch_hit[i]) begin
        fseg_found = 1'b1;
        fseg_attr = seg_attr_m[i];
      end
    end
  end

  // Memory region decode
  wire in_rom = (mreq_addr <= `ROM_LAST);
  wire in_nvm = (mreq_addr >= `NVM_FIRST) && (mreq_addr <= `NVM_LAST);
  wire in_sec_row = (mreq_addr >= `SEC_ROW_FIRST) && (mreq_addr <= `NVM_LAST);
  wire in_ram = (mreq_addr >= `RAM_FIRST) && (mreq_addr <= `RAM_LAST);
  wire in_coprocessor_exchange_ram = (mreq_addr >= `COPROCESSOR_EXCHANGE_RAM_FIRST);
  wire [15:0] xbase = {xbase_high_r, xbase_low_r};
  wire [15:0] xsize = {xsize_high_r, xsize_low_r};
  wire [16:0] xend = {1'b0, xbase} + {1'b0, xsize};
  wire in_xwin = (in_ram || in_coprocessor_exchange_ram) && (mreq_addr >= xbase) &&
    ({1'b0, mreq_addr} < xend);
  wire op_rd = (mreq_op == `OP_READ);
  wire op_wr = (mreq_op == `OP_WRITE);
  wire op_ex = (mreq_op == `OP_EXEC);

  // Copy engine runs in the mode it was started in
  wire [2:0] eff_mode = (mreq_src == `SRC_COPY) ? copy_mode_r : mreq_mode;

  reg [2:0] eff_perm;
  reg perm_ok;
  reg mem_ok;
  always @* begin
    eff_perm = in_rom ? (mseg_attr[2:0] & `ROM_PERM_MASK) : mseg_attr[2:0];
    perm_ok = mseg_found && (eff_perm != `PERM_NONE) &&
      ((op_rd && eff_perm[`PERM_R]) || (op_wr && eff_perm[`PERM_W]) ||
       (op_ex && eff_perm[`PERM_X]));
    mem_ok = 1'b0;
    case (eff_mode)
      `MODE_BOOT: mem_ok = in_sec_row && op_rd;
      `MODE_TEST: mem_ok = !(in_rom && op_wr);
      `MODE_FW: begin
        mem_ok = (in_xwin && !op_ex) || (in_sec_row && op_rd) ||
          (in_nvm && mreq_fw_from_sys && !op_ex);
      end
      `MODE_SYS: mem_ok = !(in_rom && op_wr);
      `MODE_USER: mem_ok = perm_ok;
      default: mem_ok = 1'b0;
    endcase
    if (mreq_src == `SRC_CRYPTO) begin
      mem_ok = in_coprocessor_exchange_ram && !op_ex;
    end
    if (mreq_src == `SRC_CPU && cfg_r[`CFG_NVM_CODE_NO_ROM] && mreq_code_in_nvm &&
        in_rom && op_rd) begin
      mem_ok = 1'b0;
    end
    if (mreq_src == `SRC_COPY && op_rd &&
        ((cfg_r[`CFG_COPY_NO_ROM] && in_rom) || (cfg_r[`CFG_COPY_NO_NVM] && in_nvm))) begin
      mem_ok = 1'b0;
    end
  end

  // Register access decision
  wire s_rd = !sreq_wr;
  wire fw_hw_rd = fw_ctrl_low_r[sreq_hw_id];
  wire fw_hw_wr = fw_ctrl_high_r[sreq_hw_id];
  reg sfr_ok;
  always @* begin
    sfr_ok = 1'b0;
    case (sreq_mode)
      `MODE_BOOT: begin
        sfr_ok = (sreq_group != `GRP_TEST) && (sreq_group != `GRP_SEG_CFG) &&
          (sreq_group != `GRP_CPU_BANKED);
      end
      `MODE_TEST: begin
        sfr_ok = (sreq_group != `GRP_SEG_CFG) && (sreq_group != `GRP_CPU_BANKED);
      end
      `MODE_FW: begin
        case (sreq_group)
          `GRP_FW_CFG: sfr_ok = s_rd;
          `GRP_FW_OS: sfr_ok = 1'b1;
          `GRP_HW: sfr_ok = (s_rd && (fw_hw_rd || sreq_sel == `SEL_CLKSEL)) ||
            (sreq_wr && fw_hw_wr);
          `GRP_SYS_MGMT: sfr_ok = s_rd && (sreq_sel == `SEL_CSR);
          default: sfr_ok = 1'b0;
        endcase
      end
      `MODE_SYS: begin
        sfr_ok = (sreq_group == `GRP_SEG_CFG) || (sreq_group == `GRP_SYS_MGMT) ||
          (sreq_group == `GRP_FW_CFG) || (sreq_group == `GRP_HW) ||
          (sreq_group == `GRP_CPU_BANKED);
      end
      `MODE_USER: begin
        case (sreq_group)
          `GRP_HW: sfr_ok = fseg_found &&
            (s_rd ? fseg_attr[`ATTR_HW_RD] : fseg_attr[`ATTR_HW_WR]);
          `GRP_SYS_MGMT: sfr_ok = s_rd && (sreq_sel == `SEL_CSR);
          `GRP_CPU_BANKED: sfr_ok = 1'b1;
          default: sfr_ok = 1'b0;
        endcase
      end
      default: sfr_ok = 1'b0;
    endcase
    if (sreq_group == `GRP_CPU_SHARED) begin
      sfr_ok = 1'b1;
    end
    if (s_rd && (sreq_sel == `SEL_PTR_SHADOW || sreq_sel == `SEL_KEY)) begin
      sfr_ok = 1'b0;
    end
    if (sreq_wr && sreq_sel == `SEL_RNG) begin
      sfr_ok = 1'b0;
    end
  end

  // Register port read mux
  reg [15:0] rdata_nxt;
  always @* begin
    case (reg_addr)
      `ADDR_FW_CTRL_LOW: rdata_nxt = {{(16-HW_IDS){1'b0}}, fw_ctrl_low_r};
      `ADDR_FW_CTRL_HIGH: rdata_nxt = {{(16-HW_IDS){1'b0}}, fw_ctrl_high_r};
      `ADDR_XBASE_LOW: rdata_nxt = {8'h00, xbase_low_r};
      `ADDR_XBASE_HIGH: rdata_nxt = {8'h00, xbase_high_r};
      `ADDR_XSIZE_LOW: rdata_nxt = {8'h00, xsize_low_r};
      `ADDR_XSIZE_HIGH: rdata_nxt = {8'h00, xsize_high_r};
      `ADDR_CFG: rdata_nxt = {13'h0000, cfg_r};
      `ADDR_SEG_PTR: rdata_nxt = {8'h00, seg_ptr_r};
      `ADDR_SEG_INDEX: rdata_nxt = {10'h000, seg_index_r};
      `ADDR_SEG_ATTR: rdata_nxt = {11'h000, seg_attr_m[seg_index_r]};
      `ADDR_SEG_FIRST: rdata_nxt = seg_first_m[seg_index_r];
      `ADDR_SEG_LAST: rdata_nxt = seg_last_m[seg_index_r];
      `ADDR_SEG_RELOC: rdata_nxt = seg_reloc_m[seg_index_r];
      `ADDR_STATUS: rdata_nxt = {12'h000, copy_busy_r, copy_mode_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Table memory has no reset; seg_en_r keeps unwritten entries inert
  always @(posedge ref_clk) begin
    if (reg_wr && reg_addr == `ADDR_SEG_ATTR) begin
      seg_attr_m[seg_index_r] <= reg_wdata[4:0];
    end
    if (reg_wr && reg_addr == `ADDR_SEG_FIRST) begin
      seg_first_m[seg_index_r] <= reg_wdata;
    end
    if (reg_wr && reg_addr == `ADDR_SEG_LAST) begin
      seg_last_m[seg_index_r] <= reg_wdata;
    end
    if (reg_wr && reg_addr == `ADDR_SEG_RELOC) begin
      seg_reloc_m[seg_index_r] <= reg_wdata;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fw_ctrl_low_r <= {HW_IDS{1'b0}};
      fw_ctrl_high_r <= {HW_IDS{1'b0}};
      xbase_low_r <= 8'h00;
      xbase_high_r <= 8'h00;
      xsize_low_r <= 8'h00;
      xsize_high_r <= 8'h00;
      cfg_r <= 3'h0;
      seg_ptr_r <= 8'h00;
      seg_index_r <= 6'h00;
      seg_en_r <= {SEGS{1'b0}};
      reg_rdata_r <= 16'h0000;
    end else begin
      reg_rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
      if (reg_wr) begin
        case (reg_addr)
          `ADDR_FW_CTRL_LOW: fw_ctrl_low_r <= reg_wdata[HW_IDS-1:0];
          `ADDR_FW_CTRL_HIGH: fw_ctrl_high_r <= reg_wdata[HW_IDS-1:0];
          `ADDR_XBASE_LOW: xbase_low_r <= reg_wdata[7:0];
          `ADDR_XBASE_HIGH: xbase_high_r <= reg_wdata[7:0];
          `ADDR_XSIZE_LOW: xsize_low_r <= reg_wdata[7:0];
          `ADDR_XSIZE_HIGH: xsize_high_r <= reg_wdata[7:0];
          `ADDR_CFG: cfg_r <= reg_wdata[2:0];
          `ADDR_SEG_PTR: seg_ptr_r <= reg_wdata[7:0];
          `ADDR_SEG_INDEX: seg_index_r <= reg_wdata[5:0];
          `ADDR_SEG_ATTR: seg_en_r[seg_index_r] <= (reg_wdata[2:0] != `PERM_NONE);
          default: seg_en_r <= seg_en_r;
        endcase
      end
    end
  end

  // Copy mode latch: software mode changes mid-transfer are not seen
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      copy_busy_r <= 1'b0;
      copy_mode_r <= `MODE_BOOT;
    end else if (copy_start && !copy_busy_r) begin
      copy_busy_r <= 1'b1;
      copy_mode_r <= mreq_mode;
    end else if (copy_done) begin
      copy_busy_r <= 1'b0;
    end
  end

  // Registered answers; target acts on grant only, so a deny changes nothing
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mem_grant_r <= 1'b0;
      mem_deny_r <= 1'b0;
      mem_phys_addr_r <= {AW{1'b0}};
      sfr_grant_r <= 1'b0;
      sfr_deny_r <= 1'b0;
      exc_r <= 1'b0;
    end else begin
      mem_grant_r <= mreq_valid && mem_ok;
      mem_deny_r <= mreq_valid && !mem_ok;
      mem_phys_addr_r <= (mreq_valid && mem_ok && eff_mode == `MODE_USER &&
        mreq_src != `SRC_CRYPTO) ? mreq_addr + mseg_reloc : mreq_addr;
      sfr_grant_r <= sreq_valid && sfr_ok;
      sfr_deny_r <= sreq_valid && !sfr_ok;
      exc_r <= sreq_valid && !sfr_ok;
    end
  end

endmodule
`default_nettype wire

// ==== design/access_checker_consts.vh ====
`ifndef ACCESS_CHECKER_CONSTS_VH
`define ACCESS_CHECKER_CONSTS_VH

// CPU modes
`define MODE_BOOT 3'h0
`define MODE_TEST 3'h1
`define MODE_FW 3'h2
`define MODE_SYS 3'h3
`define MODE_USER 3'h4

// Memory operations
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_EXEC 2'h2

// Memory request sources
`define SRC_CPU 2'h0
`define SRC_COPY 2'h1
`define SRC_CRYPTO 2'h2

// Permission bit positions (r, w, x)
`define PERM_R 0
`define PERM_W 1
`define PERM_X 2
`define PERM_NONE 3'h0
`define ROM_PERM_MASK 3'h5

// Virtual memory map
`define ROM_LAST 16'h3fff
`define NVM_FIRST 16'h4000
`define NVM_LAST 16'h7fff
`define SEC_ROW_FIRST 16'h7f00
`define RAM_FIRST 16'h8000
`define RAM_LAST 16'hefff
`define COPROCESSOR_EXCHANGE_RAM_FIRST 16'hf000

// Register groups
`define GRP_SEG_CFG 3'h0
`define GRP_SYS_MGMT 3'h1
`define GRP_FW_CFG 3'h2
`define GRP_FW_OS 3'h3
`define GRP_TEST 3'h4
`define GRP_HW 3'h5
`define GRP_CPU_SHARED 3'h6
`define GRP_CPU_BANKED 3'h7

// Specially handled registers
`define SEL_NONE 3'h0
`define SEL_CSR 3'h1
`define SEL_CLKSEL 3'h2
`define SEL_PTR_SHADOW 3'h3
`define SEL_RNG 3'h4
`define SEL_KEY 3'h5

// Register port offsets
`define ADDR_FW_CTRL_LOW 4'h0
`define ADDR_FW_CTRL_HIGH 4'h1
`define ADDR_XBASE_LOW 4'h2
`define ADDR_XBASE_HIGH 4'h3
`define ADDR_XSIZE_LOW 4'h4
`define ADDR_XSIZE_HIGH 4'h5
`define ADDR_CFG 4'h6
`define ADDR_SEG_PTR 4'h7
`define ADDR_SEG_INDEX 4'h8
`define ADDR_SEG_ATTR 4'h9
`define ADDR_SEG_FIRST 4'ha
`define ADDR_SEG_LAST 4'hb
`define ADDR_SEG_RELOC 4'hc
`define ADDR_STATUS 4'hd

// Configuration bits
`define CFG_NVM_CODE_NO_ROM 0
`define CFG_COPY_NO_ROM 1
`define CFG_COPY_NO_NVM 2

// Segment attribute layout: perm in [2:0], hw read [3], hw write [4]
`define ATTR_HW_RD 3
`define ATTR_HW_WR 4

`endif

// ==== verification/mode_based_access_checker_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module mode_based_access_checker_sva #(
  parameter AW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_r,
  // Memory check
  input wire logic mreq_valid,
  input wire logic [1:0] mreq_src,
  input wire logic [1:0] mreq_op,
  input wire logic [AW-1:0] mreq_addr,
  input wire logic mem_grant_r,
  input wire logic mem_deny_r,
  // Register check
  input wire logic sreq_valid,
  input wire logic sreq_wr,
  input wire logic [2:0] sreq_mode,
  input wire logic [2:0] sreq_group,
  input wire logic [2:0] sreq_sel,
  input wire logic sfr_grant_r,
  input wire logic sfr_deny_r,
  input wire logic exc_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_mem_one_answer: assert property (mreq_valid |=> mem_grant_r != mem_deny_r)
    else $error("memory request not answered once");
  a_mem_no_stray: assert property (!mreq_valid |=> !mem_grant_r && !mem_deny_r)
    else $error("memory answer without request");
  a_sfr_one_answer: assert property (sreq_valid |=> sfr_grant_r != sfr_deny_r)
    else $error("register request not answered once");
  a_sfr_no_stray: assert property (!sreq_valid |=> !sfr_grant_r && !sfr_deny_r)
    else $error("register answer without request");
  a_deny_raises_exc: assert property (exc_r == sfr_deny_r)
    else $error("exception differs from denial");
  a_shadow_unread: assert property (sreq_valid && !sreq_wr && sreq_sel == 3'h3 |=> sfr_deny_r)
    else $error("pointer shadow read granted");
  a_segcfg_sys_only: assert property (sreq_valid && sreq_group == 3'h0 && sreq_mode != 3'h3
    |=> sfr_deny_r)
    else $error("segment config reached outside system");
  a_shared_always: assert property (sreq_valid && sreq_group == 3'h6 && sreq_sel == 3'h0
    |=> sfr_grant_r)
    else $error("shared cpu register denied");
  a_banked_low_deny: assert property (sreq_valid && sreq_group == 3'h7 && sreq_mode < 3'h3
    |=> sfr_deny_r)
    else $error("banked register granted in low mode");
  a_crypto_fx_rw: assert property (mreq_valid && mreq_src == 2'h2 && mreq_op != 2'h2
    && mreq_addr >= 16'hf000 |=> mem_grant_r)
    else $error("crypto exchange ram access denied");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_r == 16'h0)
    else $error("read data outside read answer");
endmodule
`default_nettype wire

// ==== verification/access_requester.sv ====
`timescale 1ns/10ps
`default_nettype none
module access_requester (
  // Clock
  input wire logic ref_clk,
  // Memory request
  output logic mreq_valid,
  output logic [1:0] mreq_src,
  output logic [2:0] mreq_mode,
  output logic [1:0] mreq_op,
  output logic [15:0] mreq_addr,
  output logic mreq_code_in_nvm,
  output logic mreq_fw_from_sys,
  // Copy engine
  output logic copy_start,
  output logic copy_done,
  // Register request
  output logic sreq_valid,
  output logic sreq_wr,
  output logic [2:0] sreq_mode,
  output logic [2:0] sreq_group,
  output logic [2:0] sreq_sel,
  output logic [2:0] sreq_hw_id,
  output logic [15:0] fetch_addr
);
  initial begin
    {mreq_valid, mreq_src, mreq_mode, mreq_op, mreq_addr} = '0;
    {mreq_code_in_nvm, mreq_fw_from_sys, copy_start, copy_done} = '0;
    {sreq_valid, sreq_wr, sreq_mode, sreq_group, sreq_sel, sreq_hw_id, fetch_addr} = '0;
  end
  // Addresses inverted after use so stale values never pass as fresh
  task mem(input logic [6:0] k, input logic [15:0] a, input logic n, input logic f);
    @(posedge ref_clk);
    mreq_valid <= 1'b1;
    {mreq_src, mreq_mode, mreq_op, mreq_addr, mreq_code_in_nvm, mreq_fw_from_sys} <= {k, a, n, f};
    @(posedge ref_clk);
    mreq_valid <= 1'b0;
    mreq_addr <= ~a;
  endtask
  task sfr(input logic w, input logic [2:0] md, g, s, id, input logic [15:0] fa);
    @(posedge ref_clk);
    sreq_valid <= 1'b1;
    {sreq_wr, sreq_mode, sreq_group, sreq_sel, sreq_hw_id, fetch_addr} <= {w, md, g, s, id, fa};
    @(posedge ref_clk);
    sreq_valid <= 1'b0;
    fetch_addr <= ~fa;
  endtask
  task copy(input logic [2:0] md, input logic st, input logic dn);
    @(posedge ref_clk);
    {mreq_mode, copy_start, copy_done} <= {md, st, dn};
    @(posedge ref_clk);
    {copy_start, copy_done} <= 2'h0;
  endtask
endmodule
`default_nettype wire

// ==== verification/test_mode_based_access_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "access_checker_consts.vh"
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h seen %h", n, e, v); end end
module test_mode_based_access_checker;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [15:0] reg_rdata_r, mreq_addr, mem_phys_addr_r, fetch_addr;
  wire logic [2:0] mreq_mode, copy_mode_r, sreq_mode, sreq_group, sreq_sel, sreq_hw_id;
  wire logic [1:0] mreq_src, mreq_op;
  wire logic mreq_valid, mreq_code_in_nvm, mreq_fw_from_sys, mem_grant_r, mem_deny_r;
  wire logic copy_start, copy_done, sreq_valid, sreq_wr, sfr_grant_r, sfr_deny_r, exc_r;
  int compares = 0, miscompares = 0, cyc = 0;
  logic [7:0] fl = 8'h0, fh = 8'h0;
  logic ur = 1'b0, uw = 1'b0, nv = 1'b0, fs = 1'b0;
  logic [15:0] rl = 16'h0;
  always #50 ref_clk = ~ref_clk;
  mode_based_access_checker u_mode_based_access_checker (.ref_clk, .rstn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .mreq_valid, .mreq_src, .mreq_mode, .mreq_op,
    .mreq_addr, .mreq_code_in_nvm, .mreq_fw_from_sys, .mem_grant_r, .mem_deny_r,
    .mem_phys_addr_r, .copy_start, .copy_done, .copy_mode_r, .sreq_valid, .sreq_wr, .sreq_mode,
    .sreq_group, .sreq_sel, .sreq_hw_id, .fetch_addr, .sfr_grant_r, .sfr_deny_r, .exc_r);
  access_requester u_access_requester (.ref_clk, .mreq_valid, .mreq_src, .mreq_mode, .mreq_op,
    .mreq_addr, .mreq_code_in_nvm, .mreq_fw_from_sys, .copy_start, .copy_done, .sreq_valid,
    .sreq_wr, .sreq_mode, .sreq_group, .sreq_sel, .sreq_hw_id, .fetch_addr);
  // Reference decision for register groups and special selects
  function automatic logic ok(int m, int g, int w, int s, int id);
    if (s == 3 && !w || s == 4 && w || s == 5 && !w) return 1'b0;
    if (g == 6) return 1'b1;
    if (g == 7) return m >= 3;
    if (g == 0) return m == 3;
    case (m)
      0: return g != 4;
      1: return 1'b1;
      2: return g == 2 ? !w : g == 3 || g == 5 && (s == 2 && !w || (w ? fh[id] : fl[id]))
        || g == 1 && s == 1 && !w;
      3: return g == 1 || g == 2 || g == 5;
      default: return g == 5 ? (w ? uw : ur) : g == 1 && s == 1 && !w;
    endcase
  endfunction
  task rw(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rr(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK("rdata", e, reg_rdata_r)
  endtask
  // Key k is {src, mode, op}
  task m(input logic [6:0] k, input logic [15:0] a, input logic g);
    u_access_requester.mem(k, a, nv, fs);
    #1 `CHK("grant", g, mem_grant_r)
    `CHK("deny", ~g, mem_deny_r)
    if (g) `CHK("phys", a + rl, mem_phys_addr_r)
  endtask
  task seg(input logic [3:0] i, input logic [15:0] f, l, r, input logic [4:0] at);
    rw(`ADDR_SEG_INDEX, {12'h0, i});
    rw(`ADDR_SEG_FIRST, f);
    rw(`ADDR_SEG_LAST, l);
    rw(`ADDR_SEG_RELOC, r);
    rw(`ADDR_SEG_ATTR, {11'h0, at});
  endtask
  task sweep;
    for (int md = 0; md < 5; md++)
      for (int g = 0; g < 8; g++)
        for (int w = 0; w < 2; w++)
          for (int s = 0; s < 6; s++) begin
            int id;
            logic e;
            if (s != 0 && g != (s == 1 || s == 3 ? 1 : 5)) continue;
            id = $urandom_range(7);
            e = ok(md, g, w, s, id);
            u_access_requester.sfr(w[0], md[2:0], g[2:0], s[2:0], id[2:0], 16'h8010);
            #1 `CHK("sfr", e, sfr_grant_r)
            `CHK("exc", ~e, exc_r)
            `CHK("sfr_deny", ~e, sfr_deny_r)
          end
  endtask
  task done(string t);
    $display("end of %s", t);
  endtask
  task wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(32'hf661c5b8));
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    m(7'h10, 16'h8010, 1'b0);
    sweep;
    done("reset");
    fl = 8'($urandom);
    fh = 8'($urandom);
    rw(`ADDR_FW_CTRL_LOW, {8'h0, fl});
    rw(`ADDR_FW_CTRL_HIGH, {8'h0, fh});
    rw(`ADDR_SEG_PTR, 16'h1);
    seg(4'h0, 16'h8000, 16'h80ff, 16'h0100, 5'h0b);
    // ROM segment asks for write too; the mask must drop it
    seg(4'h1, 16'h0000, 16'h00ff, 16'h0000, 5'h07);
    seg(4'h2, 16'h4000, 16'h40ff, 16'h0000, 5'h17);
    seg(4'h3, 16'h4100, 16'h41ff, 16'h0000, 5'h00);
    ur = 1'b1;
    sweep;
    // Fetch from a segment that allows hardware writes but not reads
    u_access_requester.sfr(1'b1, `MODE_USER, `GRP_HW, `SEL_NONE, 3'h0, 16'h4010);
    #1 `CHK("sfr_user_wr", 1'b1, sfr_grant_r)
    u_access_requester.sfr(1'b0, `MODE_USER, `GRP_HW, `SEL_NONE, 3'h0, 16'h4010);
    #1 `CHK("sfr_user_rd", 1'b0, sfr_grant_r)
    rr(`ADDR_FW_CTRL_HIGH, {8'h0, fh});
    done("firewall");
    rl = 16'h0100;
    m(7'h10, 16'h8010, 1'b1);
    m(7'h11, 16'h8010, 1'b1);
    m(7'h12, 16'h8010, 1'b0);
    rl = 16'h0;
    m(7'h10, 16'h0010, 1'b1);
    m(7'h12, 16'h0010, 1'b1);
    m(7'h11, 16'h0010, 1'b0);
    m(7'h11, 16'h4010, 1'b1);
    m(7'h12, 16'h4010, 1'b1);
    m(7'h10, 16'h4110, 1'b0);
    m(7'h10, 16'h8200, 1'b0);
    done("user");
    rw(`ADDR_XBASE_HIGH, 16'h81);
    rw(`ADDR_XBASE_LOW, 16'h00);
    rw(`ADDR_XSIZE_HIGH, 16'h00);
    rw(`ADDR_XSIZE_LOW, 16'h10);
    m(7'h08, 16'h8100, 1'b1);
    m(7'h09, 16'h810f, 1'b1);
    m(7'h08, 16'h8110, 1'b0);
    m(7'h08, 16'h80ff, 1'b0);
    m(7'h0a, 16'h8100, 1'b0);
    m(7'h08, 16'h7f00, 1'b1);
    m(7'h00, 16'h7f00, 1'b1);
    m(7'h00, 16'h7eff, 1'b0);
    m(7'h09, 16'h4000, 1'b0);
    fs = 1'b1;
    m(7'h09, 16'h4000, 1'b1);
    fs = 1'b0;
    m(7'h4d, 16'hf000, 1'b1);
    m(7'h4c, 16'hf010, 1'b1);
    m(7'h4c, 16'h8000, 1'b0);
    done("firmware");
    nv = 1'b1;
    m(7'h0c, 16'h0100, 1'b1);
    rw(`ADDR_CFG, 16'h1);
    m(7'h0c, 16'h0100, 1'b0);
    nv = 1'b0;
    m(7'h0c, 16'h0100, 1'b1);
    rr(`ADDR_CFG, 16'h1);
    rr(4'he, 16'h0);
    rw(`ADDR_CFG, 16'h6);
    u_access_requester.copy(`MODE_SYS, 1'b1, 1'b0);
    #1 `CHK("copy_mode", `MODE_SYS, copy_mode_r)
    m(7'h20, 16'h0100, 1'b0);
    m(7'h20, 16'h4000, 1'b0);
    rw(`ADDR_CFG, 16'h0);
    // Boot would refuse this ROM read; the latched system mode must win
    m(7'h20, 16'h0100, 1'b1);
    u_access_requester.copy(`MODE_FW, 1'b1, 1'b0);
    #1 `CHK("copy_mode", `MODE_SYS, copy_mode_r)
    u_access_requester.copy(`MODE_BOOT, 1'b0, 1'b1);
    rr(`ADDR_STATUS, {12'h000, 1'b0, `MODE_SYS});
    done("copy");
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    m(7'h10, 16'h8010, 1'b0);
    rr(`ADDR_SEG_PTR, 16'h0000);
    done("second reset");
    wrap_up;
  end
endmodule
bind mode_based_access_checker mode_based_access_checker_sva #(.AW(AW)) u_sva (.ref_clk, .rstn,
  .reg_rd, .reg_rdata_r, .mreq_valid, .mreq_src, .mreq_op, .mreq_addr, .mem_grant_r,
  .mem_deny_r, .sreq_valid, .sreq_wr, .sreq_mode, .sreq_group, .sreq_sel, .sfr_grant_r,
  .sfr_deny_r, .exc_r);
`default_nettype wire
